// [design/dme_pkg.sv]
// holds register offsets, field layouts, reset values and timing counts
// for the extended mode register set and delay-line tuning block.
// assumes a 32-bit apb bus and a 250 MHz core clock.
package dme_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  // least time from mode register command to the next command
  localparam int T_MODE_REG_GAP_PS = 8000;
  // least time rounds up, never below one cycle
  localparam int MODE_REG_GAP_RAW = (T_MODE_REG_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MODE_REG_GAP_CYC = (MODE_REG_GAP_RAW < 1) ? 1 : MODE_REG_GAP_RAW;
  localparam int GAP_CNT_W = 4;

  // ------------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------------
  localparam logic [31:0] ADDR_CAL_CMD_ADDRESS = 32'hfffff540;
  localparam logic [31:0] ADDR_CAL_CMD_CTRL_STATUS = 32'hfffff544;
  localparam logic [31:0] ADDR_DLL_SLAVE_LOW_MIX_0 = 32'hfffff554;
  localparam logic [31:0] ADDR_DLL_SLAVE_LOW_MIX_1 = 32'hfffff558;
  localparam logic [31:0] ADDR_DLL_SLAVE_HIGH_MIX_0 = 32'hfffff55c;
  localparam logic [31:0] ADDR_DLL_SLAVE_HIGH_MIX_1 = 32'hfffff560;
  localparam logic [31:0] ADDR_DLL_SLAVE_LENGTH = 32'hfffff564;
  localparam logic [31:0] ADDR_DLL_MASTER_MIX = 32'hfffff568;
  localparam logic [31:0] ADDR_DLL_MASTER_LENGTH = 32'hfffff56c;
  localparam int DLL_NUM_REGS = 7;
  localparam int DLL_IDX_W = 3;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] DLL_RESET_VALUE = 32'h00000000;
  localparam logic [31:0] CAL_ADDR_RESET = 32'h00000000;

  // ------------------------------------------------------------------
  // calibration command address fields
  // ------------------------------------------------------------------
  localparam int CA_BANK_LSB = 0;
  localparam int CA_BANK_W = 2;
  localparam int CA_ROW_LSB = 2;
  localparam int CA_ROW_W = 14;
  localparam int CA_USED_W = 16;

  // ------------------------------------------------------------------
  // calibration command control/status fields
  // ------------------------------------------------------------------
  localparam int CS_BUSY_BIT = 31;
  localparam int CS_ERR_BIT = 30;
  localparam int CS_ENABLE_BIT = 24;
  localparam int CS_SELECT_BIT = 20;
  localparam int CS_CODE_LSB = 0;
  localparam int CS_CODE_W = 4;
  localparam logic [3:0] CMD_CODE_EXT_MODE_SET = 4'h3;

  // engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_DRIVE = 2'b01,
    ENG_GAP = 2'b10
  } dme_eng_state_t;

endpackage

// [design/dme_dll_bank.sv]
// holds the seven delay-line tuning registers and their read mux.
// assumes a one-cycle write strobe and index decoded by the caller.
`timescale 1ns/10ps

module dme_dll_bank (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // write and read access
  input wire logic i_wr,
  input wire logic [dme_pkg::DLL_IDX_W-1:0] i_idx,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  // all values, flattened, register 0 in the low word
  output logic [dme_pkg::DLL_NUM_REGS*32-1:0] o_values
);
  import dme_pkg::*;

  // ------------------------------------------------------------------
  // storage, one word per register
  // ------------------------------------------------------------------
  logic [31:0] val_ff [DLL_NUM_REGS];
  logic [31:0] nxt_val [DLL_NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < DLL_NUM_REGS; g++) begin : g_reg
      // reset value leaves the read strobe late in the eye; firmware retunes
      always_comb begin
        nxt_val[g] = val_ff[g];
        if (i_wr && (i_idx == DLL_IDX_W'(g))) begin
          nxt_val[g] = i_wdata;
        end
      end
      always_ff @(posedge i_clk) begin
        if (i_reset) begin
          val_ff[g] <= DLL_RESET_VALUE;
        end else begin
          val_ff[g] <= nxt_val[g];
        end
      end
      assign o_values[g*32 +: 32] = val_ff[g];
    end
  endgenerate

  // read mux; an index past the last register reads zero
  always_comb begin
    o_rdata = 32'h00000000;
    for (int i = 0; i < DLL_NUM_REGS; i++) begin
      if (i_idx == i[DLL_IDX_W-1:0]) begin
        o_rdata = val_ff[i];
      end
    end
  end

endmodule

// [design/dme_cmd_engine.sv]
// drives one mode register command onto the memory command pins and then
// waits out the mode register gap before reporting done.
// assumes start is only pulsed while the engine is idle.
`timescale 1ns/10ps

module dme_cmd_engine (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // command request
  input wire logic i_start,
  input wire logic i_cs_sel,
  input wire logic [dme_pkg::CA_BANK_W-1:0] i_bank,
  input wire logic [dme_pkg::CA_ROW_W-1:0] i_row,
  output logic o_done,
  // memory command pins, all from flops
  output logic [1:0] o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [dme_pkg::CA_BANK_W-1:0] o_bank,
  output logic [dme_pkg::CA_ROW_W-1:0] o_row
);
  import dme_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  dme_eng_state_t state_ff, nxt_state;
  logic [GAP_CNT_W-1:0] gap_ff, nxt_gap;
  logic done_ff, nxt_done;
  logic [1:0] cs_n_ff, nxt_cs_n;
  logic cmd_low_ff, nxt_cmd_low;
  logic [CA_BANK_W-1:0] bank_ff, nxt_bank;
  logic [CA_ROW_W-1:0] row_ff, nxt_row;

  // next-state logic: idle -> drive for one cycle -> gap -> idle
  always_comb begin
    nxt_state = state_ff;
    nxt_gap = gap_ff;
    nxt_done = 1'b0;
    nxt_cs_n = 2'b11;
    nxt_cmd_low = 1'b0;
    nxt_bank = bank_ff;
    nxt_row = row_ff;
    unique case (state_ff)
      ENG_IDLE: begin
        if (i_start) begin
          // ras, cas and we all low with one select low is the mode set
          nxt_cs_n = i_cs_sel ? 2'b01 : 2'b10;
          nxt_cmd_low = 1'b1;
          nxt_bank = i_bank;
          nxt_row = i_row;
          nxt_state = ENG_DRIVE;
        end
      end
      ENG_DRIVE: begin
        // command is on the pins this cycle; start the gap count
        nxt_gap = GAP_CNT_W'(MODE_REG_GAP_CYC - 1);
        nxt_state = ENG_GAP;
      end
      ENG_GAP: begin
        if (gap_ff == '0) begin
          nxt_done = 1'b1;
          nxt_state = ENG_IDLE;
        end else begin
          nxt_gap = gap_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = ENG_IDLE;
      end
    endcase
  end

  // registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_ff <= ENG_IDLE;
      gap_ff <= '0;
      done_ff <= 1'b0;
      cs_n_ff <= 2'b11;
      cmd_low_ff <= 1'b0;
      bank_ff <= '0;
      row_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      gap_ff <= nxt_gap;
      done_ff <= nxt_done;
      cs_n_ff <= nxt_cs_n;
      cmd_low_ff <= nxt_cmd_low;
      bank_ff <= nxt_bank;
      row_ff <= nxt_row;
    end
  end

  assign o_done = done_ff;
  assign o_cs_n = cs_n_ff;
  assign o_ras_n = ~cmd_low_ff;
  assign o_cas_n = ~cmd_low_ff;
  assign o_we_n = ~cmd_low_ff;
  assign o_bank = bank_ff;
  assign o_row = row_ff;

endmodule

// [design/dme_ctrl_top.sv]
// top of the extended mode register set and delay-line tuning block:
// apb slave, calibration command registers and the tuning register bank.
// assumes a single 250 MHz clock, synchronous active-high reset, and
// memory command pins that are sampled on the same clock.
`timescale 1ns/10ps

module dme_ctrl_top (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  // memory command pins
  output logic [1:0] O_MEM_CS_N,
  output logic O_MEM_RAS_N,
  output logic O_MEM_CAS_N,
  output logic O_MEM_WE_N,
  output logic [dme_pkg::CA_BANK_W-1:0] O_MEM_BANK,
  output logic [dme_pkg::CA_ROW_W-1:0] O_MEM_ROW,
  // delay-line tuning values to the read strobe delay cells
  output logic [31:0] O_DLL_SLAVE_LOW_MIX_0,
  output logic [31:0] O_DLL_SLAVE_LOW_MIX_1,
  output logic [31:0] O_DLL_SLAVE_HIGH_MIX_0,
  output logic [31:0] O_DLL_SLAVE_HIGH_MIX_1,
  output logic [31:0] O_DLL_SLAVE_LENGTH,
  output logic [31:0] O_DLL_MASTER_MIX,
  output logic [31:0] O_DLL_MASTER_LENGTH
);
  import dme_pkg::*;
  // two command words, a hole, then seven tuning words;
  // each is one aligned 32-bit word, no byte strobes,
  // and holes answer with an error

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------

  // maps a byte address to a tuning register index, or the count if none
  // full compare, so no alias of a register hits;
  // the count is one past the last index: no hit
  function automatic logic [DLL_IDX_W-1:0] dll_index(input logic [31:0] addr);
    logic [DLL_IDX_W-1:0] idx;
    idx = DLL_IDX_W'(DLL_NUM_REGS);
    unique case (addr)
      ADDR_DLL_SLAVE_LOW_MIX_0: idx = 3'd0;
      ADDR_DLL_SLAVE_LOW_MIX_1: idx = 3'd1;
      ADDR_DLL_SLAVE_HIGH_MIX_0: idx = 3'd2;
      ADDR_DLL_SLAVE_HIGH_MIX_1: idx = 3'd3;
      ADDR_DLL_SLAVE_LENGTH: idx = 3'd4;
      ADDR_DLL_MASTER_MIX: idx = 3'd5;
      ADDR_DLL_MASTER_LENGTH: idx = 3'd6;
      default: idx = DLL_IDX_W'(DLL_NUM_REGS);
    endcase
    return idx;
  endfunction

  logic [DLL_IDX_W-1:0] dll_idx;
  logic hit_dll;
  logic hit_cal_addr;
  logic hit_cal_csr;
  logic hit_any;

  // decode is shared by the read capture and the write strobe
  // the master holds the address over setup and
  // access, so one decode serves both edges
  always_comb begin
    dll_idx = dll_index(I_PADDR);
    hit_dll = (dll_idx != DLL_IDX_W'(DLL_NUM_REGS));
    hit_cal_addr = (I_PADDR == ADDR_CAL_CMD_ADDRESS);
    hit_cal_csr = (I_PADDR == ADDR_CAL_CMD_CTRL_STATUS);
    hit_any = hit_dll | hit_cal_addr | hit_cal_csr;
  end

  // ------------------------------------------------------------------
  // apb handshake
  // ------------------------------------------------------------------
  // one fixed wait-free access phase: read data is captured at the setup
  // edge so the output stays a flop, at the cost of a stale busy bit if
  // the command ends in the very same cycle.
  // pready is the setup phase one flop later, so
  // every transfer takes two cycles and never waits;
  // a hole still completes, flagged by pslverr
  logic setup_phase;
  logic access_done;
  logic wr_fire;
  logic pready_ff, nxt_pready;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;
  logic [31:0] dll_rdata;
  logic [31:0] csr_view;

  // a write lands only on the access edge with pready
  // high, and only at an address that hits a register
  assign setup_phase = I_PSEL & ~I_PENABLE;
  assign access_done = I_PSEL & I_PENABLE & pready_ff;
  assign wr_fire = access_done & I_PWRITE & hit_any;

  // ------------------------------------------------------------------
  // calibration command registers
  // ------------------------------------------------------------------
  // address word: bank low, row above, rest reads 0;
  // control word keeps enable, select and code even
  // when nothing is issued, so software sees its write;
  // operands never change under a running command
  logic [CA_USED_W-1:0] cal_addr_ff, nxt_cal_addr;
  logic busy_ff, nxt_busy;
  logic err_ff, nxt_err;
  logic enable_ff, nxt_enable;
  logic select_ff, nxt_select;
  logic [CS_CODE_W-1:0] code_ff, nxt_code;
  logic eng_start;
  logic eng_done;
  logic csr_go;

  // a write with the go bit and enable both set asks for a command
  // either bit alone only stores the fields
  assign csr_go = wr_fire & hit_cal_csr & I_PWDATA[CS_BUSY_BIT] & I_PWDATA[CS_ENABLE_BIT];

  always_comb begin
    nxt_cal_addr = cal_addr_ff;
    nxt_busy = busy_ff;
    nxt_err = err_ff;
    nxt_enable = enable_ff;
    nxt_select = select_ff;
    nxt_code = code_ff;
    eng_start = 1'b0;
    // address word is frozen while busy, like control
    if (wr_fire && hit_cal_addr && !busy_ff) begin
      // bank bits pick which extended mode register is set
      nxt_cal_addr = I_PWDATA[CA_USED_W-1:0];
    end
    // writes while a command runs are dropped so it keeps its operands
    if (wr_fire && hit_cal_csr && !busy_ff) begin
      nxt_enable = I_PWDATA[CS_ENABLE_BIT];
      nxt_select = I_PWDATA[CS_SELECT_BIT];
      nxt_code = I_PWDATA[CS_CODE_LSB +: CS_CODE_W];
      nxt_err = 1'b0;
      if (csr_go) begin
        if (I_PWDATA[CS_CODE_LSB +: CS_CODE_W] == CMD_CODE_EXT_MODE_SET) begin
          eng_start = 1'b1;
          nxt_busy = 1'b1;
        end else begin
          // unknown command codes never reach the pins
          // but keep their fields and raise the error
          nxt_err = 1'b1;
        end
      end
    end
    // busy clears only after the pins carried the command and the gap ran
    // done never meets a go: go is refused while busy
    if (eng_done) begin
      nxt_busy = 1'b0;
    end
  end

  // reset leaves no command pending, pins idle,
  // and both command words at their reset values
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      cal_addr_ff <= CAL_ADDR_RESET[CA_USED_W-1:0];
      busy_ff <= 1'b0;
      err_ff <= 1'b0;
      enable_ff <= 1'b0;
      select_ff <= 1'b0;
      code_ff <= '0;
    end else begin
      cal_addr_ff <= nxt_cal_addr;
      busy_ff <= nxt_busy;
      err_ff <= nxt_err;
      enable_ff <= nxt_enable;
      select_ff <= nxt_select;
      code_ff <= nxt_code;
    end
  end

  // status view: bit 31 high means still running, low means completed
  // a go written with enable and code 3 reads back busy until done;
  // the error stays until the next accepted control write
  always_comb begin
    csr_view = 32'h00000000;
    csr_view[CS_BUSY_BIT] = busy_ff;
    csr_view[CS_ERR_BIT] = err_ff;
    csr_view[CS_ENABLE_BIT] = enable_ff;
    csr_view[CS_SELECT_BIT] = select_ff;
    csr_view[CS_CODE_LSB +: CS_CODE_W] = code_ff;
  end

  // ------------------------------------------------------------------
  // apb answer registers
  // ------------------------------------------------------------------
  // read data is picked at the setup edge into a flop,
  // so no output follows the bus inputs directly;
  // writes and holes answer with zero data
  always_comb begin
    nxt_pready = setup_phase;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (setup_phase) begin
      nxt_pslverr = ~hit_any;
      nxt_prdata = 32'h00000000;
      if (!I_PWRITE) begin
        if (hit_dll) begin
          nxt_prdata = dll_rdata;
        end else if (hit_cal_addr) begin
          nxt_prdata = {{(32 - CA_USED_W){1'b0}}, cal_addr_ff};
        end else if (hit_cal_csr) begin
          nxt_prdata = csr_view;
        end
      end
    end
  end

  // answer flops; reset leaves the bus quiet, no error;
  // between transfers pready is low and data is stale
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= nxt_pready;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // answer ports straight from their flops
  assign O_PREADY = pready_ff;
  assign O_PRDATA = prdata_ff;
  assign O_PSLVERR = pslverr_ff;

  // ------------------------------------------------------------------
  // delay-line tuning bank
  // ------------------------------------------------------------------
  // tuning writes are taken even while a command runs:
  // the delay cells play no part in the mode set.
  // reset values stay; firmware loads the tuned set.
  // flattened bank view, register 0 in the low word
  logic [DLL_NUM_REGS*32-1:0] dll_values;

  dme_dll_bank u_dll_bank (
    .i_clk(I_CORE_CLK),
    .i_reset(I_RESET),
    .i_wr(wr_fire & hit_dll),
    .i_idx(dll_idx),
    .i_wdata(I_PWDATA),
    .o_rdata(dll_rdata),
    .o_values(dll_values)
  );

  // each value comes straight from its flop inside the bank
  assign O_DLL_SLAVE_LOW_MIX_0 = dll_values[0*32 +: 32];
  assign O_DLL_SLAVE_LOW_MIX_1 = dll_values[1*32 +: 32];
  assign O_DLL_SLAVE_HIGH_MIX_0 = dll_values[2*32 +: 32];
  assign O_DLL_SLAVE_HIGH_MIX_1 = dll_values[3*32 +: 32];
  assign O_DLL_SLAVE_LENGTH = dll_values[4*32 +: 32];
  assign O_DLL_MASTER_MIX = dll_values[5*32 +: 32];
  assign O_DLL_MASTER_LENGTH = dll_values[6*32 +: 32];

  // ------------------------------------------------------------------
  // command engine
  // ------------------------------------------------------------------
  // the select comes from the word being written so the first pin cycle
  // already carries the new select and the stored bank
  // only code 3 with enable and go gets this far;
  // the engine owns the pins: between commands the
  // selects and strobes stay high, bank and row hold;
  // its done pulse lasts one cycle and clears busy
  dme_cmd_engine u_cmd_engine (
    .i_clk(I_CORE_CLK),
    .i_reset(I_RESET),
    .i_start(eng_start),
    .i_cs_sel(I_PWDATA[CS_SELECT_BIT]),
    .i_bank(cal_addr_ff[CA_BANK_LSB +: CA_BANK_W]),
    .i_row(cal_addr_ff[CA_ROW_LSB +: CA_ROW_W]),
    .o_done(eng_done),
    .o_cs_n(O_MEM_CS_N),
    .o_ras_n(O_MEM_RAS_N),
    .o_cas_n(O_MEM_CAS_N),
    .o_we_n(O_MEM_WE_N),
    .o_bank(O_MEM_BANK),
    .o_row(O_MEM_ROW)
  );

endmodule

// [verification/dme_ctrl_monitor.sv]
// checker for the apb answer and the mode register command pins.
// assumes it is bound onto dme_ctrl_top and sees its ports only.
`timescale 1ns/10ps

module dme_ctrl_monitor
  import dme_pkg::*;
(
  // clock, reset and apb
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [31:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PSLVERR,
  // memory command pins
  input wire logic [1:0] O_MEM_CS_N,
  input wire logic O_MEM_RAS_N,
  input wire logic O_MEM_CAS_N,
  input wire logic O_MEM_WE_N,
  input wire logic [dme_pkg::CA_BANK_W-1:0] O_MEM_BANK
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);

  // decoded events; busy is not visible here, so go writes only bound causes
  logic go_wr;
  logic cmd;
  logic rd_ctrl;
  assign go_wr = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE &&
    I_PADDR == ADDR_CAL_CMD_CTRL_STATUS && I_PWDATA[CS_BUSY_BIT] && I_PWDATA[CS_ENABLE_BIT];
  assign cmd = !O_MEM_RAS_N;
  assign rd_ctrl = O_PREADY && !I_PWRITE && I_PADDR == ADDR_CAL_CMD_CTRL_STATUS;

  pready_answer_a: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("pready missing after setup");
  pready_pulse_a: assert property (O_PREADY |=> !O_PREADY)
    else $error("pready longer than one cycle");
  slverr_ready_a: assert property (O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h00000000)
    else $error("slverr without ready or with data");
  cmd_cause_a: assert property (cmd |-> $past(go_wr))
    else $error("command without go write");
  cmd_shape_a: assert property (cmd |-> !O_MEM_CAS_N && !O_MEM_WE_N &&
    $past(I_PWDATA[3:0]) == CMD_CODE_EXT_MODE_SET) else $error("command shape wrong");
  cmd_select_a: assert property (cmd |-> O_MEM_CS_N ==
    ($past(I_PWDATA[CS_SELECT_BIT]) ? 2'b01 : 2'b10)) else $error("wrong chip select");
  cmd_single_a: assert property (cmd |=> (!cmd) [*4])
    else $error("command repeated too soon");
  idle_pins_a: assert property (O_MEM_RAS_N |->
    O_MEM_CS_N == 2'b11 && $stable(O_MEM_BANK)) else $error("pins moved while idle");
  busy_hold_a: assert property (rd_ctrl && (cmd || $past(cmd) || $past(cmd, 2)) |->
    O_PRDATA[CS_BUSY_BIT]) else $error("busy clear too early");

  cs0_cmd_c: cover property (cmd && O_MEM_CS_N == 2'b10);
  cs1_cmd_c: cover property (cmd && O_MEM_CS_N == 2'b01);
  slverr_c: cover property (O_PSLVERR);
endmodule

bind dme_ctrl_top dme_ctrl_monitor u_mon (.I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR),
  .O_MEM_CS_N(O_MEM_CS_N), .O_MEM_RAS_N(O_MEM_RAS_N), .O_MEM_CAS_N(O_MEM_CAS_N),
  .O_MEM_WE_N(O_MEM_WE_N), .O_MEM_BANK(O_MEM_BANK));

// [verification/dme_mem_model.sv]
// behavioural memory rank pair that counts extended mode set commands.
// assumes command pins are sampled on the controller's rising edge.
`timescale 1ns/10ps

module dme_mem_model (
  // clock and command pins
  input wire logic i_clk,
  input wire logic [1:0] i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [1:0] i_bank,
  // what the ranks received
  output logic [7:0] o_cnt_cs0,
  output logic [7:0] o_cnt_cs1,
  output logic [1:0] o_last_bank
);
  initial begin
    o_cnt_cs0 = 8'h00;
    o_cnt_cs1 = 8'h00;
    o_last_bank = 2'h0;
  end

  // a rank takes the mode set only when its own select is low
  always @(posedge i_clk) begin
    if (!i_ras_n && !i_cas_n && !i_we_n) begin
      if (!i_cs_n[0]) o_cnt_cs0 <= o_cnt_cs0 + 8'h01;
      if (!i_cs_n[1]) o_cnt_cs1 <= o_cnt_cs1 + 8'h01;
      o_last_bank <= i_bank;
    end
  end
endmodule

// [verification/testbench.sv]
// self-checking bench: apb master tasks, one task per scenario.
// assumes the checker is bound and the memory model sits on the pins.
`timescale 1ns/10ps

module testbench;
  import dme_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [1:0] cs_n;
  logic ras_n, cas_n, we_n;
  logic [1:0] bank;
  logic [13:0] row;
  logic [31:0] dll [7];
  logic [7:0] cnt0, cnt1;
  logic [1:0] mbank;
  int n_errors = 0;
  int num_checks = 0;

  always #2 clk = ~clk;

  dme_ctrl_top u_dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr), .O_MEM_CS_N(cs_n), .O_MEM_RAS_N(ras_n),
    .O_MEM_CAS_N(cas_n), .O_MEM_WE_N(we_n), .O_MEM_BANK(bank), .O_MEM_ROW(row),
    .O_DLL_SLAVE_LOW_MIX_0(dll[0]), .O_DLL_SLAVE_LOW_MIX_1(dll[1]),
    .O_DLL_SLAVE_HIGH_MIX_0(dll[2]), .O_DLL_SLAVE_HIGH_MIX_1(dll[3]),
    .O_DLL_SLAVE_LENGTH(dll[4]), .O_DLL_MASTER_MIX(dll[5]), .O_DLL_MASTER_LENGTH(dll[6]));
  dme_mem_model u_mem (.i_clk(clk), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
    .i_we_n(we_n), .i_bank(bank), .o_cnt_cs0(cnt0), .o_cnt_cs1(cnt1), .o_last_bank(mbank));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      chk("pready wait", 32'h1, 32'h0);
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // poll the completion bit under a bounded count
  task automatic wait_done();
    logic [31:0] rd;
    logic er;
    for (int i = 0; i < 20; i++) begin
      apb(1'b0, ADDR_CAL_CMD_CTRL_STATUS, 32'h0, rd, er);
      if (rd[CS_BUSY_BIT] === 1'b0) return;
    end
    chk("busy wait", 32'h0, 32'h1);
    final_report();
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] rd;
    logic er;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ADDR_DLL_SLAVE_LOW_MIX_0 + 32'(4 * i), 32'h0, rd, er);
      chk("dll reset read", DLL_RESET_VALUE, rd);
      chk("dll reset port", DLL_RESET_VALUE, dll[i]);
    end
    apb(1'b0, ADDR_CAL_CMD_ADDRESS, 32'h0, rd, er);
    chk("cmd address reset", CAL_ADDR_RESET, rd);
  endtask

  // bad code and missing go must issue nothing; bad code flags an error
  task automatic t_refused();
    logic [31:0] rd;
    logic er;
    apb(1'b1, ADDR_CAL_CMD_CTRL_STATUS, 32'h81000005, rd, er);
    apb(1'b0, ADDR_CAL_CMD_CTRL_STATUS, 32'h0, rd, er);
    chk("error on bad code", 32'h1, {31'h0, rd[CS_ERR_BIT]});
    apb(1'b1, ADDR_CAL_CMD_CTRL_STATUS, 32'h01000003, rd, er);
    apb(1'b0, ADDR_CAL_CMD_CTRL_STATUS, 32'h0, rd, er);
    chk("error after plain write", 32'h0, {31'h0, rd[CS_ERR_BIT]});
    chk("busy after refusal", 32'h0, {31'h0, rd[CS_BUSY_BIT]});
    chk("cs0 count refused", 32'h0, {24'h0, cnt0});
    chk("cs1 count refused", 32'h0, {24'h0, cnt1});
  endtask

  // the start-up pair of mode set steps for banks 2 and 3
  task automatic t_emrs();
    logic [31:0] rd;
    logic er;
    logic [7:0] e0, e1;
    e0 = 8'h00;
    e1 = 8'h00;
    for (int b = 2; b < 4; b++) begin
      apb(1'b1, ADDR_CAL_CMD_ADDRESS, 32'(b), rd, er);
      apb(1'b0, ADDR_CAL_CMD_ADDRESS, 32'h0, rd, er);
      chk("cmd address", 32'(b), rd);
      for (int c = 0; c < 2; c++) begin
        apb(1'b1, ADDR_CAL_CMD_CTRL_STATUS, c ? 32'h81100003 : 32'h81000003, rd, er);
        apb(1'b0, ADDR_CAL_CMD_CTRL_STATUS, 32'h0, rd, er);
        chk("busy right after go", 32'h1, {31'h0, rd[CS_BUSY_BIT]});
        chk("error cleared", 32'h0, {31'h0, rd[CS_ERR_BIT]});
        wait_done();
        if (c) e1 = e1 + 8'h01;
        else e0 = e0 + 8'h01;
        chk("cs0 count", {24'h0, e0}, {24'h0, cnt0});
        chk("cs1 count", {24'h0, e1}, {24'h0, cnt1});
        chk("rank bank", 32'(b), {30'h0, mbank});
        chk("rank row", 32'h0, {18'h0, row});
      end
    end
  endtask

  // both recommended tuning sets, read back and seen at the ports
  task automatic t_dll();
    logic [31:0] tbl [2][7];
    logic [31:0] rd;
    logic er;
    tbl[0] = '{32'h33333333, 32'h00000003, 32'h33333333, 32'h00000003,
               32'h00000003, 32'h0000000a, 32'h00000002};
    tbl[1] = '{32'h66666666, 32'h00000006, 32'h66666666, 32'h00000006,
               32'h00000003, 32'h00000000, 32'h00000002};
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 7; i++)
        apb(1'b1, ADDR_DLL_SLAVE_LOW_MIX_0 + 32'(4 * i), tbl[s][i], rd, er);
      for (int i = 0; i < 7; i++) begin
        apb(1'b0, ADDR_DLL_SLAVE_LOW_MIX_0 + 32'(4 * i), 32'h0, rd, er);
        chk("dll read", tbl[s][i], rd);
        chk("dll port", tbl[s][i], dll[i]);
      end
    end
  endtask

  // holes in the map answer with an error and change nothing
  task automatic t_unmapped();
    logic [31:0] rd;
    logic er;
    apb(1'b0, 32'hfffff550, 32'h0, rd, er);
    chk("unmapped read err", 32'h1, {31'h0, er});
    chk("unmapped read data", 32'h0, rd);
    apb(1'b1, 32'hfffff570, 32'hffffffff, rd, er);
    chk("unmapped write err", 32'h1, {31'h0, er});
    chk("master length kept", 32'h00000002, dll[6]);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_refused();
    t_emrs();
    t_dll();
    t_unmapped();
    final_report();
  end
endmodule
